// *** verilog/clk_switch_device.sv ***
// CPU clock selection and switchover logic with reset stabilisation wait
//
// Summary of operation
// - Divider bits 0-2, source select bit 4
// - Old clock runs on for some instructions
// - Bit 5 shows the active clock source
// - Main divider change: 1 to 16 instructions
// - Main to sub: ratio over 2..64
// - Latency counted in old-clock instructions
// - Host splits divider and main-to-sub changes
// - Sub-to-main write may change divider too
// - Wait 2^17 main periods after reset
// - Start at slowest main speed after wait, or at a setting written during it
// - Host moves to sub only when stable
// - Host times restart stabilisation; holds return only while a wait from an earlier write runs
// - Stop bit acts only while on sub
// - Reset values 04H and 00H
// - Sub clock instruction time ignores divider
// - Prescale bit clear halves main system clock
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "clk_switch_defs.svh"
module clk_switch_device #(
  parameter int STAB_CYCLES = `MAIN_STAB_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  // Link to the host
  clk_switch_if.device    link,
  // CPU side
  output logic            cpu_step_out,
  output logic            cpu_ready_out,
  output logic            cpu_on_sub_out,
  output logic [2:0]      cpu_div_out,
  // Oscillator control
  output logic            main_osc_enable_out,
  output logic            sub_feedback_off_out
);
  clk_switch_pkg::dev_regs_type r_reg;
  clk_switch_pkg::dev_regs_type r_next;

  logic                   stab_busy;
  logic                   stab_load;
  logic [2:0]             eff_div;
  logic [2:0]             main_shift;
  logic [`STEP_CNT_W-1:0] period;
  logic                   osc_run;
  logic                   src_runs;
  logic                   new_src;
  logic [2:0]             new_div;
  logic [`LAT_CNT_W-1:0]  latency;

  // Named so the reset branch can pick fields out of them
  localparam logic [7:0] CTRL_INIT = `CTRL_RESET;
  localparam logic [7:0] MODE_INIT = `MODE_RESET;

  // Ceiling of the main-to-sub ratio over 2^k
  function automatic logic [`LAT_CNT_W-1:0] sub_latency(input logic [2:0] k);
    int unsigned v;
    v = (`MAIN_PER_SUB + (1 << k) - 1) >> k;
    if (v == 0) begin
      v = 1;
    end
    return `LAT_CNT_W'(v);
  endfunction : sub_latency

  wait_counter u_stab (
    .core_clk_in   (core_clk_in),
    .reset_in      (reset_in),
    .load_in       (stab_load),
    .load_value_in (`STAB_CNT_W'(STAB_CYCLES)),
    .busy_out      (stab_busy)
  );

  // Settings 5..7 are prohibited; treat them as the slowest
  assign eff_div    = (r_reg.act_div > `SLOWEST_DIV) ? `SLOWEST_DIV : r_reg.act_div;
  assign main_shift = 3'(eff_div + {2'h0, ~r_reg.prescale});

  // Main instruction time halves per divider step below slowest
  always_comb begin
    if (r_reg.act_src) begin
      period = `STEP_CNT_W'(`SUB_INSTR_CYCLES);
    end else begin
      period = `STEP_CNT_W'(`SLOW_INSTR_CYCLES >> (3'(`SLOW_SHIFT) - main_shift));
    end
  end

  // Stopping the oscillator while the CPU still runs on it would hang the core
  assign osc_run  = ~(r_reg.osc_stop & r_reg.act_src);
  assign src_runs = r_reg.act_src | osc_run;

  assign new_src = link.cfg_data[`CTRL_SRC_BIT];
  assign new_div = link.cfg_data[`CTRL_DIV_MSB:`CTRL_DIV_LSB];

  // Latency in instructions of the clock now in effect
  always_comb begin
    latency = `LAT_CNT_W'(1);
    if (!r_reg.act_src && new_src) begin
      latency = sub_latency(3'(main_shift + 3'h1));
    end else if (!r_reg.act_src && !new_src && new_div != r_reg.act_div) begin
      if (new_div > `SLOWEST_DIV) begin
        latency = `LAT_CNT_W'(1);
      end else begin
        latency = `LAT_CNT_W'(`MAIN_LAT_MAX >> new_div);
      end
    end
  end

  always_comb begin
    r_next      = r_reg;
    r_next.step = 1'b0;
    stab_load   = 1'b0;
    unique case (r_reg.phase)
      clk_switch_pkg::PH_STAB: begin
        if (!r_reg.started) begin
          stab_load      = 1'b1;
          r_next.started = 1'b1;
        end else if (!stab_busy) begin
          r_next.phase    = clk_switch_pkg::PH_RUN;
          r_next.step_cnt = '0;
        end
      end
      clk_switch_pkg::PH_RUN,
      clk_switch_pkg::PH_SWITCH: begin
        if (src_runs) begin
          if (r_reg.step_cnt >= period - `STEP_CNT_W'(1)) begin
            r_next.step     = 1'b1;
            r_next.step_cnt = '0;
          end else begin
            r_next.step_cnt = r_reg.step_cnt + `STEP_CNT_W'(1);
          end
        end
        // Count down only on instruction boundaries of the old clock
        if (r_reg.phase == clk_switch_pkg::PH_SWITCH && r_next.step) begin
          if (r_reg.lat_cnt <= `LAT_CNT_W'(1)) begin
            r_next.act_div = r_reg.div_sel;
            r_next.act_src = r_reg.src_sel;
            r_next.phase   = clk_switch_pkg::PH_RUN;
            r_next.lat_cnt = '0;
          end else begin
            r_next.lat_cnt = r_reg.lat_cnt - `LAT_CNT_W'(1);
          end
        end
      end
    endcase

    if (link.cfg_wr) begin
      if (link.cfg_sel == `SEL_CTRL) begin
        r_next.div_sel  = new_div;
        r_next.src_sel  = new_src;
        r_next.fb_ctrl  = link.cfg_data[`CTRL_FB_BIT];
        r_next.osc_stop = link.cfg_data[`CTRL_STOP_BIT];
        if (r_reg.phase == clk_switch_pkg::PH_STAB) begin
          // CPU not yet running, nothing to hand over
          r_next.act_div = new_div;
          r_next.act_src = new_src;
        end else begin
          // A later write restarts the count with the newest target
          r_next.phase   = clk_switch_pkg::PH_SWITCH;
          r_next.lat_cnt = latency;
        end
      end else begin
        r_next.prescale = link.cfg_data[`MODE_PRESCALE_BIT];
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      r_reg          <= '0;
      r_reg.phase    <= clk_switch_pkg::PH_STAB;
      r_reg.div_sel  <= CTRL_INIT[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
      r_reg.src_sel  <= CTRL_INIT[`CTRL_SRC_BIT];
      r_reg.fb_ctrl  <= CTRL_INIT[`CTRL_FB_BIT];
      r_reg.osc_stop <= CTRL_INIT[`CTRL_STOP_BIT];
      r_reg.prescale <= MODE_INIT[`MODE_PRESCALE_BIT];
      r_reg.act_div  <= CTRL_INIT[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
      r_reg.act_src  <= CTRL_INIT[`CTRL_SRC_BIT];
    end else begin
      r_reg <= r_next;
    end
  end

  // Readback; status bit is the source actually in use
  always_comb begin
    link.ctrl_rd                               = '0;
    link.ctrl_rd[`CTRL_DIV_MSB:`CTRL_DIV_LSB]  = r_reg.div_sel;
    link.ctrl_rd[`CTRL_SRC_BIT]                = r_reg.src_sel;
    link.ctrl_rd[`CTRL_STATUS_BIT]             = r_reg.act_src;
    link.ctrl_rd[`CTRL_FB_BIT]                 = r_reg.fb_ctrl;
    link.ctrl_rd[`CTRL_STOP_BIT]               = r_reg.osc_stop;
    link.mode_rd                               = '0;
    link.mode_rd[`MODE_PRESCALE_BIT]           = r_reg.prescale;
  end

  assign link.busy         = (r_reg.phase == clk_switch_pkg::PH_SWITCH);
  assign link.ready        = (r_reg.phase != clk_switch_pkg::PH_STAB);
  assign link.cpu_step     = r_reg.step;
  assign link.main_osc_run = osc_run;

  assign cpu_step_out         = r_reg.step;
  assign cpu_ready_out        = (r_reg.phase != clk_switch_pkg::PH_STAB);
  assign cpu_on_sub_out       = r_reg.act_src;
  assign cpu_div_out          = r_reg.act_div;
  // Oscillator left running during reset itself, as stop and source both reset to 0
  assign main_osc_enable_out  = osc_run;
  assign sub_feedback_off_out = r_reg.fb_ctrl;
endmodule : clk_switch_device

// *** verilog/clk_switch_defs.svh ***
// Offsets, field positions, reset values and timing counts of the clock switchover block
`ifndef CLK_SWITCH_DEFS_SVH
`define CLK_SWITCH_DEFS_SVH

// Processor clock control register layout
`define CTRL_RESET         8'h04
`define CTRL_DIV_LSB       0
`define CTRL_DIV_MSB       2
`define CTRL_SRC_BIT       4
`define CTRL_STATUS_BIT    5
`define CTRL_FB_BIT        6
`define CTRL_STOP_BIT      7
`define SLOWEST_DIV        3'h4

// Oscillation mode selection register layout
`define MODE_RESET         8'h00
`define MODE_PRESCALE_BIT  0

// Link register select codes
`define SEL_CTRL           1'h0
`define SEL_MODE           1'h1

// Host register map
`define HOST_CTRL_ADDR     4'h0
`define HOST_MODE_ADDR     4'h1
`define HOST_STAT_ADDR     4'h2
`define STAT_READY_BIT     0
`define STAT_BUSY_BIT      1
`define STAT_OSC_RUN_BIT   2
`define STAT_REFUSED_BIT   3
`define STAT_WAIT_BIT      4
`define STAT_SPLIT_BIT     5

// Timing
`define CORE_CLK_NS        100
`define MAIN_OSC_PERIOD_NS 200
`define MAIN_OSC_CYCLES    (`MAIN_OSC_PERIOD_NS / `CORE_CLK_NS)
`define MAIN_STAB_PERIODS  131072
`define MAIN_STAB_CYCLES   (`MAIN_STAB_PERIODS * `MAIN_OSC_CYCLES)
`define SUB_OSC_PERIOD_NS  30518
`define SUB_OSC_CYCLES     (`SUB_OSC_PERIOD_NS / `CORE_CLK_NS)
`define SUB_INSTR_PERIODS  4
`define SUB_INSTR_CYCLES   (`SUB_INSTR_PERIODS * `SUB_OSC_CYCLES)
`define SLOW_INSTR_NS      12800
`define SLOW_INSTR_CYCLES  (`SLOW_INSTR_NS / `CORE_CLK_NS)
`define SLOW_SHIFT         5
`define MAIN_PER_SUB       153
`define MAIN_LAT_MAX       16
`define STAB_CNT_W         19
`define STEP_CNT_W         11
`define LAT_CNT_W          8

`endif

// *** verilog/clk_switch_pkg.sv ***
// Types shared by the clock switchover device, its host and the wait counter
package clk_switch_pkg;

  typedef enum logic [2:0] {
    PH_STAB   = 3'h1,
    PH_RUN    = 3'h2,
    PH_SWITCH = 3'h4
  } dev_phase_type;

  typedef struct packed {
    dev_phase_type phase;
    logic          started;
    logic [2:0]    div_sel;
    logic          src_sel;
    logic          fb_ctrl;
    logic          osc_stop;
    logic          prescale;
    logic [2:0]    act_div;
    logic          act_src;
    logic [7:0]    lat_cnt;
    logic [10:0]   step_cnt;
    logic          step;
  } dev_regs_type;

  typedef struct packed {
    logic        cfg_wr;
    logic        cfg_sel;
    logic [7:0]  cfg_data;
    logic        split;
    logic [7:0]  split_data;
    logic        refused;
    logic [7:0]  rdata;
  } host_regs_type;

  typedef struct packed {
    logic [18:0] count;
  } wait_regs_type;

endpackage : clk_switch_pkg

// *** verilog/clk_switch_if.sv ***
// Link between the clock switchover device and its controlling host
`timescale 1ns/100ps
interface clk_switch_if;
  logic       cfg_wr;
  logic       cfg_sel;
  logic [7:0] cfg_data;
  logic [7:0] ctrl_rd;
  logic [7:0] mode_rd;
  logic       busy;
  logic       ready;
  logic       cpu_step;
  logic       main_osc_run;

  modport device (
    input  cfg_wr, cfg_sel, cfg_data,
    output ctrl_rd, mode_rd, busy, ready, cpu_step, main_osc_run
  );

  modport host (
    output cfg_wr, cfg_sel, cfg_data,
    input  ctrl_rd, mode_rd, busy, ready, cpu_step, main_osc_run
  );
endinterface : clk_switch_if

// *** verilog/wait_counter.sv ***
// Loadable down counter that times oscillator stabilisation
`timescale 1ns/100ps
`include "clk_switch_defs.svh"
module wait_counter (
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   reset_in,
  // Control
  input  wire logic                   load_in,
  input  wire logic [`STAB_CNT_W-1:0] load_value_in,
  // Status
  output logic                        busy_out
);
  clk_switch_pkg::wait_regs_type r_reg;
  clk_switch_pkg::wait_regs_type r_next;

  always_comb begin
    r_next = r_reg;
    if (load_in) begin
      r_next.count = load_value_in;
    end else if (r_reg.count != '0) begin
      r_next.count = r_reg.count - 19'h1;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign busy_out = (r_reg.count != '0);
endmodule : wait_counter

// *** verilog/clk_switch_host.sv ***
// Controller that forwards software clock settings to the switchover device
`timescale 1ns/100ps
`include "clk_switch_defs.svh"
module clk_switch_host #(
  parameter int STAB_CYCLES = `MAIN_STAB_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  // Software port
  input  wire logic [3:0] sw_addr_in,
  input  wire logic [7:0] sw_wdata_in,
  input  wire logic       sw_wr_in,
  input  wire logic       sw_rd_in,
  output logic [7:0]      sw_rdata_out,
  // Subsystem oscillator state
  input  wire logic       sub_osc_stable_in,
  // Link to the device
  clk_switch_if.host      link
);
  clk_switch_pkg::host_regs_type r_reg;
  clk_switch_pkg::host_regs_type r_next;

  logic       wait_busy;
  logic       wait_load;
  logic [7:0] d;
  logic [7:0] cur;
  logic [7:0] status;

  wait_counter u_restart (
    .core_clk_in   (core_clk_in),
    .reset_in      (reset_in),
    .load_in       (wait_load),
    .load_value_in (`STAB_CNT_W'(STAB_CYCLES)),
    .busy_out      (wait_busy)
  );

  assign cur = link.ctrl_rd;

  always_comb begin
    status                    = '0;
    status[`STAT_READY_BIT]   = link.ready;
    status[`STAT_BUSY_BIT]    = link.busy;
    status[`STAT_OSC_RUN_BIT] = link.main_osc_run;
    status[`STAT_REFUSED_BIT] = r_reg.refused;
    status[`STAT_WAIT_BIT]    = wait_busy;
    status[`STAT_SPLIT_BIT]   = r_reg.split;
  end

  always_comb begin
    r_next        = r_reg;
    r_next.cfg_wr = 1'b0;
    r_next.rdata  = '0;
    wait_load     = 1'b0;
    d             = sw_wdata_in;
    // Second half of a split write once the first has been applied
    if (r_reg.split && !link.busy && !r_reg.cfg_wr && !sw_wr_in) begin
      r_next.cfg_wr   = 1'b1;
      r_next.cfg_sel  = `SEL_CTRL;
      r_next.cfg_data = r_reg.split_data;
      r_next.split    = 1'b0;
    end
    if (sw_wr_in) begin
      unique case (sw_addr_in)
        `HOST_CTRL_ADDR: begin
          r_next.split = 1'b0;
          if (d[`CTRL_SRC_BIT] && !cur[`CTRL_SRC_BIT]) begin
            if (!sub_osc_stable_in) begin
              d[`CTRL_SRC_BIT] = 1'b0;
              r_next.refused   = 1'b1;
            end else if (d[`CTRL_DIV_MSB:`CTRL_DIV_LSB] != cur[`CTRL_DIV_MSB:`CTRL_DIV_LSB]) begin
              r_next.split      = 1'b1;
              r_next.split_data = d;
              d[`CTRL_SRC_BIT]  = 1'b0;
            end
          end else if (!d[`CTRL_SRC_BIT] && cur[`CTRL_SRC_BIT] && wait_busy) begin
            d[`CTRL_SRC_BIT] = 1'b1;
            r_next.refused   = 1'b1;
          end
          if (cur[`CTRL_STOP_BIT] && !d[`CTRL_STOP_BIT]) begin
            wait_load = 1'b1;
          end
          r_next.cfg_wr   = 1'b1;
          r_next.cfg_sel  = `SEL_CTRL;
          r_next.cfg_data = d;
        end
        `HOST_MODE_ADDR: begin
          r_next.cfg_wr   = 1'b1;
          r_next.cfg_sel  = `SEL_MODE;
          r_next.cfg_data = d;
        end
        `HOST_STAT_ADDR: begin
          if (d[`STAT_REFUSED_BIT]) begin
            r_next.refused = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (sw_rd_in) begin
      unique case (sw_addr_in)
        `HOST_CTRL_ADDR: r_next.rdata = link.ctrl_rd;
        `HOST_MODE_ADDR: r_next.rdata = link.mode_rd;
        `HOST_STAT_ADDR: r_next.rdata = status;
        default:         r_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.cfg_wr   = r_reg.cfg_wr;
  assign link.cfg_sel  = r_reg.cfg_sel;
  assign link.cfg_data = r_reg.cfg_data;
  assign sw_rdata_out  = r_reg.rdata;
endmodule : clk_switch_host

// *** bench/clk_switch_assertions.sv ***
// Link-level property checker for the clock switchover host and device pair
`timescale 1ns/100ps
module clk_switch_assertions #(
  parameter int STAB_CYCLES = 20
) (
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  input wire logic       cfg_wr,
  input wire logic       cfg_sel,
  input wire logic [7:0] cfg_data,
  input wire logic [7:0] ctrl_rd,
  input wire logic [7:0] mode_rd,
  input wire logic       busy,
  input wire logic       ready,
  input wire logic       cpu_step,
  input wire logic       main_osc_run
);
  // Cycles since reset release, frozen once the wait ends
  logic [31:0] since_reg;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      since_reg <= 32'h0;
    end else if (!ready) begin
      since_reg <= since_reg + 32'h1;
    end
  end

  // Worst pending switchover outlasts a delay range, so it is counted
  logic [15:0] busy_cnt_reg;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_cnt_reg <= 16'h0;
    end else if (busy) begin
      busy_cnt_reg <= busy_cnt_reg + 16'h1;
    end else begin
      busy_cnt_reg <= 16'h0;
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  property p_reset_values;
    $fell(reset_in) |-> ctrl_rd == 8'h04 && mode_rd == 8'h00;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
  property p_ready_not_early;
    $rose(ready) |-> since_reg >= STAB_CYCLES;
  endproperty
  a_ready_not_early: assert property (p_ready_not_early) else $error("ready too early");
  property p_ready_in_time;
    !ready |-> since_reg <= STAB_CYCLES + 8;
  endproperty
  a_ready_in_time: assert property (p_ready_in_time) else $error("ready too late");
  property p_slow_after_wait;
    $rose(ready) |-> ctrl_rd[2:0] == 3'h4 && !ctrl_rd[5] && !mode_rd[0];
  endproperty
  a_slow_after_wait: assert property (p_slow_after_wait) else $error("not slowest main speed");
  property p_busy_after_write;
    ready && cfg_wr && cfg_sel == 1'h0 |=> busy;
  endproperty
  a_busy_after_write: assert property (p_busy_after_write) else $error("write applied at once");
  property p_status_on_expiry;
    $changed(ctrl_rd[5]) && $past(ready) |-> $past(busy);
  endproperty
  a_status_on_expiry: assert property (p_status_on_expiry) else $error("status moved early");
  property p_busy_bounded;
    busy && !ctrl_rd[5] |-> busy_cnt_reg <= 16'h0898;
  endproperty
  a_busy_bounded: assert property (p_busy_bounded) else $error("latency overrun");
  property p_stop_only_on_sub;
    !main_osc_run |-> ctrl_rd[5] && ctrl_rd[7];
  endproperty
  a_stop_only_on_sub: assert property (p_stop_only_on_sub) else $error("oscillator stopped on main");
  property p_osc_mode_select_reg_apply;
    cfg_wr && cfg_sel == 1'h1 |=> mode_rd == {7'h00, $past(cfg_data[0])};
  endproperty
  a_osc_mode_select_reg_apply: assert property (p_osc_mode_select_reg_apply) else $error("prescale not applied");
  property p_split_on_link;
    cfg_wr && cfg_sel == 1'h0 && cfg_data[4] && !ctrl_rd[4] |-> cfg_data[2:0] == ctrl_rd[2:0];
  endproperty
  a_split_on_link: assert property (p_split_on_link) else $error("divider sent with source");
  property p_step_pulse;
    cpu_step |=> !cpu_step;
  endproperty
  a_step_pulse: assert property (p_step_pulse) else $error("step wider than a cycle");
endmodule : clk_switch_assertions

// *** bench/testbench.sv ***
// Self-checking bench for the clock switchover host and device pair
`timescale 1ns/100ps
module testbench;
  localparam int STAB = 20;
  // Worst path is a few sub instructions of 1220 cycles plus polling
  localparam int LIMIT = 60000;
  logic       core_clk_in;
  logic       reset_in;
  logic [3:0] sw_addr_in;
  logic [7:0] sw_wdata_in;
  logic       sw_wr_in;
  logic       sw_rd_in;
  logic [7:0] sw_rdata_out;
  logic       sub_osc_stable_in;
  logic       cpu_on_sub_out;
  logic [2:0] cpu_div_out;
  logic [7:0] rd;
  int         num_errors;
  int         comparisons;

  clk_switch_if clk_switch_if_inst ();
  clk_switch_device #(.STAB_CYCLES(STAB)) clk_switch_device_inst (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .link(clk_switch_if_inst.device),
    .cpu_step_out(), .cpu_ready_out(), .cpu_on_sub_out(cpu_on_sub_out), .cpu_div_out(cpu_div_out),
    .main_osc_enable_out(), .sub_feedback_off_out()
  );
  clk_switch_host #(.STAB_CYCLES(STAB)) clk_switch_host_inst (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in),
    .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out),
    .sub_osc_stable_in(sub_osc_stable_in), .link(clk_switch_if_inst.host)
  );
  clk_switch_assertions #(.STAB_CYCLES(STAB)) clk_switch_assertions_inst (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .cfg_wr(clk_switch_if_inst.cfg_wr),
    .cfg_sel(clk_switch_if_inst.cfg_sel), .cfg_data(clk_switch_if_inst.cfg_data),
    .ctrl_rd(clk_switch_if_inst.ctrl_rd), .mode_rd(clk_switch_if_inst.mode_rd), .busy(clk_switch_if_inst.busy),
    .ready(clk_switch_if_inst.ready), .cpu_step(clk_switch_if_inst.cpu_step),
    .main_osc_run(clk_switch_if_inst.main_osc_run)
  );

  always #50 core_clk_in = ~core_clk_in;

  task automatic stop_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    sw_addr_in <= a;
    sw_wdata_in <= d;
    sw_wr_in <= 1'h1;
    @(posedge core_clk_in);
    sw_wr_in <= 1'h0;
  endtask : sw_write

  task automatic sw_read(input logic [3:0] a);
    @(posedge core_clk_in);
    sw_addr_in <= a;
    sw_rd_in <= 1'h1;
    @(posedge core_clk_in);
    sw_rd_in <= 1'h0;
    @(negedge core_clk_in);
    rd = sw_rdata_out;
  endtask : sw_read

  // Polls one register bit; bounded so a stuck flag ends as a mismatch
  task automatic poll(input logic [3:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      sw_read(a);
      n++;
    end while (rd[b] !== v && n < 3000);
    check("poll", 16'(rd[b]), 16'(v));
  endtask : poll

  task automatic step_gap(input logic [15:0] exp);
    int c;
    c = 0;
    @(negedge core_clk_in);
    while (clk_switch_if_inst.cpu_step !== 1'h1 && c < 3000) begin
      @(negedge core_clk_in);
      c++;
    end
    c = 0;
    do begin
      @(negedge core_clk_in);
      c++;
    end while (clk_switch_if_inst.cpu_step !== 1'h1 && c < 3000);
    check("step_gap", 16'(c), exp);
  endtask : step_gap

  // Counts old-clock instructions while the switchover is pending
  task automatic lat_count(input logic [15:0] exp);
    int c;
    int t;
    c = 0;
    t = 0;
    while (clk_switch_if_inst.busy !== 1'h1 && t < 20) begin
      @(negedge core_clk_in);
      t++;
    end
    while (clk_switch_if_inst.busy === 1'h1 && t < 3000) begin
      if (clk_switch_if_inst.cpu_step === 1'h1) c++;
      @(negedge core_clk_in);
      t++;
    end
    if (clk_switch_if_inst.cpu_step === 1'h1) c++;
    check("latency", 16'(c), exp);
  endtask : lat_count

  task automatic t_reset();
    sw_read(4'h0);
    check("ctrl", 16'(rd), 16'h0004);
    sw_read(4'h1);
    check("mode", 16'(rd), 16'h0000);
    sw_write(4'hF, 8'hFF);
    sw_read(4'hF);
    check("unmapped", 16'(rd), 16'h0000);
    poll(4'h2, 0, 1'h1);
    step_gap(16'h0080);
  endtask : t_reset

  task automatic t_divider();
    sw_write(4'h1, 8'h01);
    sw_read(4'h1);
    check("mode", 16'(rd), 16'h0001);
    for (int d = 0; d < 5; d++) begin
      sw_write(4'h0, 8'(d));
      lat_count(16'(16 >> d));
      step_gap(16'(128 >> (5 - d)));
      sw_read(4'h0);
      check("ctrl", 16'(rd), 16'(d));
    end
    sw_write(4'h0, 8'h04);
    lat_count(16'h0001);
  endtask : t_divider

  task automatic t_to_sub();
    sw_write(4'h0, 8'h02);
    lat_count(16'h0004);
    sw_write(4'h0, 8'h12);
    sw_read(4'h2);
    check("refused", 16'(rd[3]), 16'h0001);
    sw_read(4'h0);
    check("ctrl", 16'(rd), 16'h0002);
    sw_write(4'h2, 8'h08);
    sub_osc_stable_in <= 1'h1;
    poll(4'h2, 1, 1'h0);
    sw_write(4'h0, 8'h12);
    lat_count(16'h0014);
    sw_read(4'h0);
    check("ctrl", 16'(rd), 16'h0032);
    check("on_sub", 16'(cpu_on_sub_out), 16'h0001);
    step_gap(16'h04C4);
  endtask : t_to_sub

  task automatic t_restart();
    sw_write(4'h0, 8'hB2);
    poll(4'h2, 1, 1'h0);
    check("osc_run", 16'(clk_switch_if_inst.main_osc_run), 16'h0000);
    sw_write(4'h0, 8'h32);
    sw_read(4'h2);
    check("restart_wait", 16'(rd[4]), 16'h0001);
    check("osc_run", 16'(clk_switch_if_inst.main_osc_run), 16'h0001);
    sw_write(4'h0, 8'h00);
    sw_read(4'h0);
    check("held_sub", 16'(rd[4]), 16'h0001);
    poll(4'h2, 4, 1'h0);
    sw_write(4'h2, 8'h08);
    sw_write(4'h0, 8'h00);
    poll(4'h0, 5, 1'h0);
    check("div", 16'(cpu_div_out), 16'h0000);
    step_gap(16'h0004);
  endtask : t_restart

  task automatic t_split();
    sw_write(4'h0, 8'h11);
    poll(4'h0, 5, 1'h1);
    sw_read(4'h0);
    check("ctrl", 16'(rd), 16'h0031);
  endtask : t_split

  initial begin
    repeat (LIMIT) @(posedge core_clk_in);
    num_errors++;
    stop_test();
  end

  initial begin
    core_clk_in = 1'h0;
    reset_in = 1'h1;
    sw_addr_in = 4'h0;
    sw_wdata_in = 8'h00;
    sw_wr_in = 1'h0;
    sw_rd_in = 1'h0;
    sub_osc_stable_in = 1'h0;
    num_errors = 0;
    comparisons = 0;
    repeat (8) @(posedge core_clk_in);
    reset_in <= 1'h0;
    t_reset();
    t_divider();
    t_to_sub();
    t_restart();
    t_split();
    stop_test();
  end
endmodule : testbench
